// ===== sepf_pkg.sv
// Shared constants and carrier types of the singles event packet formatter.
// Assumes one system clock domain; all widths are fixed at build time.
package sepf_pkg;

  // Channel and sample geometry.
  localparam int NUM_CH    = 16;
  localparam int SAMPLE_W  = 12;
  localparam int SUM_W     = 16;
  localparam int ESUM_W    = 18;
  localparam int CHEN_W    = 6;
  localparam int CHEN_LSB  = 10;
  localparam int FRAC_W    = 4;
  localparam int XTAL_W    = 8;
  localparam int TIME_W    = 4;

  // Nominal periods in units of 100 ps, as the slice arithmetic assumes.
  localparam int SYS_PERIOD_100PS   = 125;
  localparam int ADC_PERIOD_100PS   = 250;
  localparam int SLICE_PERIOD_100PS = 1000;

  // Packets per slice: ceil(R * slice / sys) with R = sys / adc.
  localparam int PKTS_PER_SLICE =
    (SYS_PERIOD_100PS * SLICE_PERIOD_100PS + ADC_PERIOD_100PS * SYS_PERIOD_100PS - 1) /
    (ADC_PERIOD_100PS * SYS_PERIOD_100PS);

  // Pipeline depth in slices: ceil(max ticks / slice width) + 1.
  localparam int MAX_TICKS   = 15;
  localparam int PIPE_DEPTH  = (MAX_TICKS + PKTS_PER_SLICE - 1) / PKTS_PER_SLICE + 1;

  // Packet layout.
  localparam int PKT_W       = 32;
  localparam int PID_LSB     = 28;
  localparam int PAY_W       = 28;
  localparam int WORD_PAY_W  = PAY_W * PKTS_PER_SLICE;
  localparam logic [3:0] PID_SINGLES = 4'h1;
  localparam int ADDR_FLD_W  = 9;
  localparam int CNT_LSB     = 9;
  localparam int CNT_W       = 4;
  localparam int UNUSED_W    = 3;
  localparam int CHEN_BASE   = 16;

  // Settings payload layout.
  localparam int SET_TICKS_LSB = 0;
  localparam int SET_TICKS_W   = 4;

  // Lookup table selectors on the detector memory port.
  localparam logic [1:0] LUT_XTAL = 2'h0;
  localparam logic [1:0] LUT_EWIN = 2'h1;
  localparam logic [1:0] LUT_TIME = 2'h2;
  localparam int LUT_ADDR_W = 16;
  localparam int LUT_DATA_W = 16;

  // Reset values.
  localparam logic [3:0] TICKS_RST = 4'h4;

  typedef struct packed {
    logic             valid;
    logic [PKT_W-1:0] data;
  } sepf_pkt_t;

  typedef struct packed {
    logic                  valid;
    logic [1:0]            tbl;
    logic [LUT_ADDR_W-1:0] addr;
  } sepf_lut_req_t;

  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_INTEG = 4'h1,
    S_DIVX  = 4'h2,
    S_DIVY  = 4'h3,
    S_XTAL  = 4'h4,
    S_EWIN  = 4'h5,
    S_TIME  = 4'h6,
    S_WAIT  = 4'h7,
    S_SEND  = 4'h8
  } sepf_state_t;

endpackage

// ===== sepf_frac_div.sv
// Fractional divider: quotient = floor(num * 2^FRAC_W / den), restoring form.
// Assumes num < den; num == den or a zero divisor yields an all-ones quotient.
`timescale 1ns/1ps
module sepf_frac_div
  import sepf_pkg::*;
(
  // Clock and reset.
  input  wire logic              i_mclk,
  input  wire logic              i_reset,
  // Request.
  input  wire logic              i_start,
  input  wire logic [ESUM_W-1:0] i_num,
  input  wire logic [ESUM_W-1:0] i_den,
  // Answer.
  output logic                   o_done,
  output logic [FRAC_W-1:0]      o_quot
);

  logic [ESUM_W:0]   rem_q, rem_d;
  logic [ESUM_W-1:0] den_q, den_d;
  logic [FRAC_W-1:0] quot_q, quot_d;
  logic [2:0]        cnt_q, cnt_d;
  logic              done_q, done_d;
  logic [ESUM_W:0]   shifted;

  // One quotient bit per cycle; four cycles keep the adder short.
  always_comb begin
    rem_d   = rem_q;
    den_d   = den_q;
    quot_d  = quot_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    shifted = {rem_q[ESUM_W-1:0], 1'b0};
    if (i_start) begin
      rem_d = {1'b0, i_num};
      den_d = i_den;
      cnt_d = 3'(FRAC_W);
    end else if (cnt_q != 3'h0) begin
      if (shifted >= {1'b0, den_q}) begin
        rem_d  = shifted - {1'b0, den_q};
        quot_d = {quot_q[FRAC_W-2:0], 1'b1};
      end else begin
        rem_d  = shifted;
        quot_d = {quot_q[FRAC_W-2:0], 1'b0};
      end
      cnt_d = cnt_q - 3'h1;
      done_d = (cnt_q == 3'h1);
    end
  end

  // Registers only.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rem_q  <= '0;
      den_q  <= '0;
      quot_q <= '0;
      cnt_q  <= 3'h0;
      done_q <= 1'b0;
    end else begin
      rem_q  <= rem_d;
      den_q  <= den_d;
      quot_q <= quot_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign o_done = done_q;
  assign o_quot = quot_q;

endmodule // sepf_frac_div

// ===== sepf_formatter.sv
// Singles event processing and packet framing for one output lane group.
// Assumes timing, ADC tick and slice boundary inputs are synchronous to i_mclk,
// and detector memory answers one cycle after a request is presented.
`timescale 1ns/1ps
module sepf_formatter
  import sepf_pkg::*;
(
  // Clock and reset.
  input  wire logic                             i_mclk,
  input  wire logic                             i_reset,
  // Front end.
  input  wire logic [NUM_CH-1:0]                i_timing,
  input  wire logic                             i_adc_tick,
  input  wire logic [NUM_CH-1:0][SAMPLE_W-1:0]  i_adc_sample,
  input  wire logic                             i_slice_start,
  // Acquisition settings.
  input  wire logic                             i_set_we,
  input  wire logic [PKT_W-1:0]                 i_set_data,
  // Detector memory lookup port.
  output sepf_lut_req_t                         o_lut_req,
  input  wire logic [LUT_DATA_W-1:0]            i_lut_rdata,
  // Event output.
  output sepf_pkt_t                             o_pkt,
  output logic [LUT_DATA_W-1:0]                 o_evt_time,
  output logic                                  o_busy
);

  sepf_state_t                    state_q, state_d;
  logic [NUM_CH-1:0]              timing_q;
  logic [NUM_CH-1:0]              rise;
  logic [NUM_CH-1:0][SUM_W-1:0]   sum_q, sum_d;
  logic [NUM_CH-1:0]              trig_q, trig_d;
  logic [3:0]                     ticks_q, ticks_d;
  logic [3:0]                     tcnt_q, tcnt_d;
  logic [ESUM_W-1:0]              e_q, e_d;
  logic [FRAC_W-1:0]              x_q, x_d, y_q, y_d;
  logic [XTAL_W-1:0]              xtal_q, xtal_d;
  logic [TIME_W-1:0]              phase_q, phase_d, raw_q, raw_d;
  logic [2:0]                     slices_q, slices_d;
  logic [1:0]                     lph_q, lph_d, beat_q, beat_d;
  logic                           dstart_q, dstart_d;
  logic [WORD_PAY_W-1:0]          pay_q, pay_d;
  sepf_lut_req_t                  lut_q, lut_d;
  sepf_pkt_t                      pkt_q, pkt_d;
  logic [LUT_DATA_W-1:0]          time_q, time_d;
  logic                           ddone;
  logic [FRAC_W-1:0]              dquot;
  logic [ESUM_W-1:0]              dnum;

  // Six-bit energy from the top field of one channel sum; the sum ends where
  // that field ends, so nothing above it can overflow and no clamp is needed.
  function automatic logic [CHEN_W-1:0] ch_energy(input logic [SUM_W-1:0] s);
    ch_energy = s[CHEN_LSB +: CHEN_W];
  endfunction

  // Widening sum used for both estimator numerators.
  function automatic logic [ESUM_W-1:0] wsum(input logic [SUM_W-1:0] a,
                                             input logic [SUM_W-1:0] b);
    wsum = ESUM_W'(a) + ESUM_W'(b);
  endfunction

  // Payload of one event word: header low, channel energies above.
  function automatic logic [WORD_PAY_W-1:0] build_payload(
      input logic [NUM_CH-1:0][SUM_W-1:0] s, input logic [NUM_CH-1:0] t);
    logic [4:0] n;
    n = 5'h0;
    build_payload = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      n = n + 5'(t[i]);
      build_payload[CHEN_BASE + i*CHEN_W +: CHEN_W] = ch_energy(s[i]);
    end
    build_payload[CNT_LSB +: CNT_W] = n[4] ? 4'hf : n[3:0];
  endfunction

  // Numerator of the estimator being divided: A+B for X, A+C for Y.
  assign dnum = (state_q == S_DIVX) ? wsum(sum_q[0], sum_q[1])
                                    : wsum(sum_q[0], sum_q[2]);

  sepf_frac_div u_div (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_start (dstart_q),
    .i_num   (dnum),
    .i_den   (e_q),
    .o_done  (ddone),
    .o_quot  (dquot)
  );

  // Rising edges on the timing lines; an OR of them starts an event.
  assign rise = i_timing & ~timing_q;

  // Event sequencer, framing and settings.
  always_comb begin
    state_d  = state_q;
    sum_d    = sum_q;
    trig_d   = trig_q;
    ticks_d  = ticks_q;
    tcnt_d   = tcnt_q;
    e_d      = e_q;
    x_d      = x_q;
    y_d      = y_q;
    xtal_d   = xtal_q;
    raw_d    = raw_q;
    slices_d = slices_q;
    lph_d    = lph_q;
    beat_d   = beat_q;
    dstart_d = 1'b0;
    pay_d    = pay_q;
    lut_d    = '0;
    pkt_d    = '0;
    time_d   = time_q;
    // The slice phase is the coarse arrival time of a trigger.
    phase_d  = i_slice_start ? '0 : phase_q + 4'h1;
    // Only the low nibble is kept; the rest of the payload is reserved.
    if (i_set_we)
      ticks_d = i_set_data[SET_TICKS_LSB +: SET_TICKS_W];
    // Slices elapsed since the trigger, saturating at the pipeline depth.
    if (state_q != S_IDLE && i_slice_start && slices_q != 3'(PIPE_DEPTH))
      slices_d = slices_q + 3'h1;
    case (state_q)
      S_IDLE: begin
        if (|rise) begin
          state_d  = S_INTEG;
          sum_d    = '0;
          trig_d   = rise;
          tcnt_d   = 4'h0;
          raw_d    = phase_q;
          slices_d = 3'h0;
        end
      end
      S_INTEG: begin
        trig_d = trig_q | rise;
        if (i_adc_tick) begin
          for (int i = 0; i < NUM_CH; i++)
            sum_d[i] = sum_q[i] + SUM_W'(i_adc_sample[i]);
          tcnt_d = tcnt_q + 4'h1;
          // A count of zero wraps and integrates sixteen ticks; the host avoids it.
          if (tcnt_q + 4'h1 == ticks_q) begin
            state_d  = S_DIVX;
            dstart_d = 1'b1;
          end
        end
      end
      S_DIVX: begin
        if (ddone) begin
          x_d      = dquot;
          state_d  = S_DIVY;
          dstart_d = 1'b1;
        end
      end
      S_DIVY: begin
        if (ddone) begin
          y_d     = dquot;
          state_d = S_XTAL;
          lph_d   = 2'h0;
        end
      end
      S_XTAL: begin
        lph_d = lph_q + 2'h1;
        if (lph_q == 2'h0) begin
          lut_d.valid = 1'b1;
          lut_d.tbl   = LUT_XTAL;
          lut_d.addr  = LUT_ADDR_W'({x_q, y_q});
        end else if (lph_q == 2'h2) begin
          xtal_d  = i_lut_rdata[XTAL_W-1:0];
          state_d = S_EWIN;
          lph_d   = 2'h0;
        end
      end
      S_EWIN: begin
        lph_d = lph_q + 2'h1;
        if (lph_q == 2'h0) begin
          lut_d.valid = 1'b1;
          lut_d.tbl   = LUT_EWIN;
          lut_d.addr  = {xtal_q, e_q[ESUM_W-1 -: 8]};
        end else if (lph_q == 2'h2) begin
          lph_d   = 2'h0;
          // Events outside the window are dropped here.
          state_d = i_lut_rdata[0] ? S_TIME : S_IDLE;
        end
      end
      S_TIME: begin
        lph_d = lph_q + 2'h1;
        if (lph_q == 2'h0) begin
          lut_d.valid = 1'b1;
          lut_d.tbl   = LUT_TIME;
          lut_d.addr  = {xtal_q, 4'h0, raw_q};
        end else if (lph_q == 2'h2) begin
          time_d  = i_lut_rdata;
          pay_d   = build_payload(sum_q, trig_q);
          state_d = S_WAIT;
        end
      end
      S_WAIT: begin
        // Leave on the boundary once the pipeline depth has run out.
        if (i_slice_start && slices_q == 3'(PIPE_DEPTH)) begin
          state_d    = S_SEND;
          beat_d     = 2'h1;
          pkt_d.valid = 1'b1;
          pkt_d.data = {PID_SINGLES, pay_q[0 +: PAY_W]};
        end
      end
      S_SEND: begin
        // One word per cycle: the sequencer is busy until the last beat.
        pkt_d.valid = 1'b1;
        pkt_d.data  = {PID_SINGLES, pay_q[beat_q*PAY_W +: PAY_W]};
        beat_d      = beat_q + 2'h1;
        if (beat_q == 2'(PKTS_PER_SLICE - 1))
          state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
    // Energy is latched with the divider start so both estimators share it.
    if (state_q == S_INTEG && dstart_d) begin
      e_d = '0;
      for (int i = 0; i < 4; i++)
        e_d = e_d + ESUM_W'(sum_d[i]);
    end
  end

  // Registers only.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_q  <= S_IDLE;
      timing_q <= '0;
      sum_q    <= '0;
      trig_q   <= '0;
      ticks_q  <= TICKS_RST;
      tcnt_q   <= 4'h0;
      e_q      <= '0;
      x_q      <= '0;
      y_q      <= '0;
      xtal_q   <= '0;
      phase_q  <= '0;
      raw_q    <= '0;
      slices_q <= 3'h0;
      lph_q    <= 2'h0;
      beat_q   <= 2'h0;
      dstart_q <= 1'b0;
      pay_q    <= '0;
      lut_q    <= '0;
      pkt_q    <= '0;
      time_q   <= '0;
    end else begin
      state_q  <= state_d;
      timing_q <= i_timing;
      sum_q    <= sum_d;
      trig_q   <= trig_d;
      ticks_q  <= ticks_d;
      tcnt_q   <= tcnt_d;
      e_q      <= e_d;
      x_q      <= x_d;
      y_q      <= y_d;
      xtal_q   <= xtal_d;
      phase_q  <= phase_d;
      raw_q    <= raw_d;
      slices_q <= slices_d;
      lph_q    <= lph_d;
      beat_q   <= beat_d;
      dstart_q <= dstart_d;
      pay_q    <= pay_d;
      lut_q    <= lut_d;
      pkt_q    <= pkt_d;
      time_q   <= time_d;
    end
  end

  logic busy_q;

  // Busy flag kept as its own flop so the output is registered.
  always_ff @(posedge i_mclk) begin
    if (i_reset)
      busy_q <= 1'b0;
    else
      busy_q <= (state_d != S_IDLE);
  end

  assign o_lut_req  = lut_q;
  assign o_pkt      = pkt_q;
  assign o_evt_time = time_q;
  assign o_busy     = busy_q;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  pkt_ident_a: assert property (o_pkt.valid |-> o_pkt.data[31:28] == 4'h1)
    else $error("packet identifier is not the singles code");

  hdr_fields_a: assert property ($rose(o_pkt.valid) |->
      o_pkt.data[8:0] == 9'h0 && o_pkt.data[15:13] == 3'h0)
    else $error("header address or unused bits not zero");

  burst_len_a: assert property ($rose(o_pkt.valid) |->
      o_pkt.valid [*4] ##1 !o_pkt.valid)
    else $error("event burst is not four packets");

  slice_align_a: assert property ($rose(o_pkt.valid) |->
      $past(i_slice_start) && $past(slices_q) == 3'(PIPE_DEPTH))
    else $error("burst not aligned to a slice after the pipeline depth");

  trig_start_a: assert property (state_q == S_IDLE && |rise |=>
      state_q == S_INTEG && slices_q == 3'h0)
    else $error("rising timing edge did not start an event");

  integ_end_a: assert property (state_q == S_INTEG && i_adc_tick &&
      tcnt_q + 4'h1 == ticks_q |=> state_q == S_DIVX ##1 u_div.cnt_q == 3'h4)
    else $error("integration did not end on the programmed tick");

  xtal_req_a: assert property (state_q == S_XTAL && lph_q == 2'h0 |=>
      o_lut_req.valid && o_lut_req.tbl == LUT_XTAL && o_lut_req.addr[7:0] == {x_q, y_q})
    else $error("crystal lookup not issued from the estimators");

  ewin_drop_a: assert property (state_q == S_EWIN && lph_q == 2'h2 &&
      !i_lut_rdata[0] |=> state_q == S_IDLE ##1 !o_pkt.valid)
    else $error("event outside the energy window was not dropped");

endmodule // sepf_formatter

// ===== sepf_mem_model.sv
// Detector memory model that answers each lookup on the cycle after its request.
// Assumes requests are registered and the answer is sampled one edge later.
`timescale 1ns/1ps
module sepf_mem_model
  import sepf_pkg::*;
(
  // Clock.
  input  wire logic            i_mclk,
  // Lookup port.
  input  wire sepf_lut_req_t   i_req,
  input  wire logic            i_pass,
  output logic [LUT_DATA_W-1:0] o_rdata
);
  // Last crystal handed out, so the window lookup can prove it reused it.
  logic [7:0] xtal_seen = 8'h00;
  // A start value keeps the idle toggling from sticking at unknown.
  initial o_rdata = 16'h0f0f;
  // Idle cycles invert the bus, so a late sample never sees a stale answer.
  always @(posedge i_mclk) begin
    if (i_req.valid === 1'b1) begin
      case (i_req.tbl)
        LUT_XTAL: begin
          o_rdata   <= {8'h00, i_req.addr[7:0] ^ 8'ha5};
          xtal_seen <= i_req.addr[7:0] ^ 8'ha5;
        end
        // A window lookup with the wrong crystal fails, so the event is lost.
        LUT_EWIN: o_rdata <= {15'h0000, i_pass && i_req.addr[15:8] == xtal_seen};
        default:  o_rdata <= i_req.addr;
      endcase
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule // sepf_mem_model

// ===== test_sepf_formatter.sv
// Self-checking bench for the singles event packet formatter.
// Assumes one system clock; the bench is front end, slice source and receiver.
`timescale 1ns/1ps
module test_sepf_formatter;
  import sepf_pkg::*;
  logic                            i_mclk = 1'b0;
  logic                            i_reset = 1'b1;
  logic [NUM_CH-1:0]               i_timing = '0;
  logic                            i_adc_tick = 1'b0;
  logic [NUM_CH-1:0][SAMPLE_W-1:0] i_adc_sample;
  logic                            i_slice_start = 1'b0;
  logic                            i_set_we = 1'b0;
  logic [PKT_W-1:0]                i_set_data = '0;
  logic                            pass = 1'b1;
  sepf_lut_req_t                   o_lut_req;
  logic [LUT_DATA_W-1:0]           i_lut_rdata;
  logic [LUT_DATA_W-1:0]           o_evt_time;
  sepf_pkt_t                       o_pkt;
  logic                            o_busy;
  logic [PKT_W-1:0]                beats [8];
  logic                            gap = 1'b0;
  logic                            prev_v = 1'b0;
  logic                            prev_sl = 1'b0;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int nb = 0;
  int sl = 0;
  int t0 = 0;

  sepf_formatter uut (.i_mclk(i_mclk), .i_reset(i_reset), .i_timing(i_timing),
    .i_adc_tick(i_adc_tick), .i_adc_sample(i_adc_sample), .i_slice_start(i_slice_start),
    .i_set_we(i_set_we), .i_set_data(i_set_data), .o_lut_req(o_lut_req),
    .i_lut_rdata(i_lut_rdata), .o_pkt(o_pkt), .o_evt_time(o_evt_time), .o_busy(o_busy));
  sepf_mem_model mem (.i_mclk(i_mclk), .i_req(o_lut_req), .i_pass(pass),
    .o_rdata(i_lut_rdata));

  always #4 i_mclk = ~i_mclk;

  // ADC ticks at half rate and a boundary every eight clocks, as a 100 ns slice.
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    i_adc_tick <= (cyc % 2 == 1);
    i_slice_start <= (cyc % 8 == 7);
  end

  // A hang is cut short well beyond the few hundred cycles the whole run needs.
  always @(posedge i_mclk) begin
    if (cyc >= 3000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Receiver side: captures each burst and notes gaps and where it started.
  always @(posedge i_mclk) begin
    prev_v <= o_pkt.valid;
    prev_sl <= i_slice_start;
    if (i_slice_start) sl <= sl + 1;
    if (o_pkt.valid === 1'b1) begin
      chk("packet id", o_pkt.data[31:28], PID_SINGLES);
      if (nb == 0) begin
        chk("burst after boundary", prev_sl, 1'b1);
        chk("pipeline slices", (sl - t0) >= PIPE_DEPTH, 1'b1);
      end
      if (nb > 0 && prev_v !== 1'b1) gap <= 1'b1;
      if (nb < 8) beats[nb] <= o_pkt.data;
      nb <= nb + 1;
    end
  end

  // One event: optional settings write, trigger, late trigger, and an ignored retrigger when in window.
  task automatic run_event(input logic [3:0] tk, input logic ok, input logic wr);
    logic [SUM_W-1:0]      s [NUM_CH];
    logic [WORD_PAY_W-1:0] p;
    logic [3:0]            x;
    logic [3:0]            y;
    logic [3:0]            ph;
    int                    e;
    int                    k;
    for (k = 0; k < NUM_CH; k++) s[k] = SUM_W'(tk) * SUM_W'(i_adc_sample[k]);
    e = int'(s[0]) + int'(s[1]) + int'(s[2]) + int'(s[3]);
    x = 4'(((int'(s[0]) + int'(s[1])) * 16) / e);
    y = 4'(((int'(s[0]) + int'(s[2])) * 16) / e);
    p = '0;
    p[12:9] = 4'h3;
    for (k = 0; k < NUM_CH; k++) p[16 + 6 * k +: 6] = s[k][15:10];
    pass <= ok;
    i_set_we <= wr;
    i_set_data <= {28'hfffffff, tk};
    @(posedge i_mclk);
    i_set_we <= 1'b0;
    // Slice phase at this edge is the coarse time the trigger will latch next edge.
    ph = 4'(cyc % 8);
    nb = 0;
    gap = 1'b0;
    t0 = sl;
    i_timing <= 16'h0009;
    @(posedge i_mclk);
    i_timing <= 16'h0029;
    if (ok) begin
      repeat (2 * tk + 14) @(posedge i_mclk);
      i_timing <= 16'h0000;
      @(posedge i_mclk);
      i_timing <= 16'h0080;
      @(posedge i_mclk);
    end
    i_timing <= 16'h0000;
    repeat (2) @(posedge i_mclk);
    k = 0;
    while (o_busy !== 1'b0 && k < 400) begin
      @(posedge i_mclk);
      k++;
    end
    repeat (2) @(posedge i_mclk);
    chk("idle reached", k < 400, 1'b1);
    chk("beat count", nb, ok ? 4 : 0);
    if (ok) begin
      chk("no gap", gap, 1'b0);
      for (k = 0; k < 4; k++) chk("packet", beats[k], {PID_SINGLES, p[28 * k +: 28]});
      chk("event time", o_evt_time, {{x, y} ^ 8'ha5, 4'h0, ph});
    end
    $display("test ticks %0d window %0d done", tk, ok);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Reset values, then the reset tick count, two and fifteen ticks and a dropped event.
  initial begin
    for (int c = 0; c < NUM_CH; c++) i_adc_sample[c] = 12'h300 + 12'(c) * 12'h040;
    repeat (5) @(posedge i_mclk);
    chk("reset valid", o_pkt.valid, 1'b0);
    chk("reset busy", o_busy, 1'b0);
    chk("reset lut", o_lut_req, '0);
    chk("reset time", o_evt_time, '0);
    i_reset <= 1'b0;
    // Let the first boundary pass so the slice phase is settled before a trigger.
    repeat (3) @(posedge i_mclk);
    run_event(4'h4, 1'b1, 1'b0);
    run_event(4'h2, 1'b1, 1'b1);
    run_event(4'hf, 1'b1, 1'b1);
    run_event(4'h3, 1'b0, 1'b1);
    run_event(4'h3, 1'b1, 1'b1);
    end_sim();
  end
endmodule // test_sepf_formatter
